//--- rtl/qdfe_engine.sv
// Queue descriptor fetch engine: per-queue contexts, fetch control and status.
`timescale 1ns/100ps
module qdfe_engine #(
  parameter int NQ = 4,
  parameter int QW = 2,
  parameter int DW = 64,
  parameter int MRRS_BYTES = 512
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ctx_wr_i,
  input wire logic ctx_clr_i,
  input wire logic [1:0] ctx_sel_i,
  input wire logic [QW-1:0] ctx_qid_i,
  input wire logic [qdfe_pkg::SW_W-1:0] ctx_wdata_i,
  output logic [qdfe_pkg::SW_W-1:0] ctx_rdata_o,
  input wire logic pidx_upd_i,
  input wire logic [QW-1:0] pidx_qid_i,
  input wire logic [15:0] pidx_val_i,
  input wire logic pidx_arm_i,
  input wire logic crd_valid_i,
  input wire logic [QW-1:0] crd_qid_i,
  input wire logic [15:0] crd_val_i,
  input wire logic [2:0] status_period_select_i,
  output logic fetch_valid_o,
  input wire logic fetch_ready_i,
  output logic [QW-1:0] fetch_qid_o,
  output logic [63:0] fetch_addr_o,
  output logic [15:0] fetch_cnt_o,
  input wire logic cpl_valid_i,
  input wire logic [QW-1:0] cpl_qid_i,
  input wire logic [DW-1:0] cpl_data_i,
  input wire logic cpl_last_i,
  input wire logic cpl_err_i,
  output logic dsc_valid_o,
  input wire logic dsc_ready_i,
  output logic [DW-1:0] dsc_data_o,
  output logic [QW-1:0] dsc_qid_o,
  output logic dsc_err_o,
  output logic dsc_last_o,
  output logic dsc_mm_o,
  output logic dsc_bypass_o,
  input wire logic done_valid_i,
  input wire logic [QW-1:0] done_qid_i,
  input wire logic [15:0] done_cidx_i,
  input wire logic done_err_i,
  output logic wb_valid_o,
  output logic [QW-1:0] wb_qid_o,
  output logic [15:0] wb_cidx_o,
  output logic irq_valid_o,
  output logic [QW-1:0] irq_qid_o,
  output logic [qdfe_pkg::VEC_W-1:0] irq_vec_o,
  output logic irq_aggr_o,
  output logic marker_valid_o,
  output logic [QW-1:0] marker_qid_o,
  output logic queue_status_event_valid_o,
  output logic [QW-1:0] evt_qid_o,
  output logic [15:0] evt_avail_o,
  output logic evt_arm_o
);
  localparam int BW = DW + QW + 4;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] ring_avail(input logic [15:0] p, input logic [15:0] c,
                                             input logic [3:0] rs_idx);
    logic [16:0] rs;
    rs = 17'(qdfe_pkg::RING_MIN) << rs_idx;
    ring_avail = (p >= c) ? 16'(p - c) : 16'(17'(p) + rs - 17'(c));
  endfunction

  // ==========================================================
  // Per-queue state, then shared scan, completion space and read-pointer state
  logic [qdfe_pkg::SW_W-1:0] sw_r [NQ];
  logic [15:0] cidx_r [NQ];
  logic [15:0] done_r [NQ];
  logic [15:0] credt_r [NQ];
  logic [15:0] use_r [NQ];
  logic [qdfe_pkg::FPND_W-1:0] fpnd_r [NQ];
  logic pcie_r [NQ];
  logic act_r [NQ];
  logic [QW-1:0] scan_r;
  logic [8:0] free_r;
  logic [qdfe_pkg::CPL_AW-1:0] wp_r;
  logic [qdfe_pkg::CPL_AW-1:0] rp_r;
  logic rdv_r;

  // ==========================================================
  // Completion and status decode for the done queue
  wire [qdfe_pkg::SW_W-1:0] dctx = sw_r[done_qid_i];
  wire [15:0] dmask = 16'((17'h00001 << status_period_select_i) - 17'h00001);
  wire d_idle = done_cidx_i == dctx[15:0];
  wire d_int = !dctx[qdfe_pkg::B_BYPASS];
  wire d_per = dctx[qdfe_pkg::B_INTVL] && d_int && ((done_cidx_i & dmask) == 16'h0000);
  wire d_chk = dctx[qdfe_pkg::B_CHK] && d_idle;
  wire d_stat = done_valid_i && (d_per || d_chk || done_err_i) && !dctx[qdfe_pkg::B_ERR_SENT];
  wire d_wb = d_stat && dctx[qdfe_pkg::B_WBK_EN];
  wire d_irq_due = d_stat && dctx[qdfe_pkg::B_IRQ_EN];
  wire d_irq = d_irq_due && dctx[qdfe_pkg::B_ARM];
  wire d_set_req = d_irq_due && !dctx[qdfe_pkg::B_ARM] && done_err_i;
  wire d_set_nolast = d_irq_due && !dctx[qdfe_pkg::B_ARM] && !done_err_i && d_idle && d_int;
  wire d_mrk = done_valid_i && d_int && !dctx[qdfe_pkg::B_MRK_DIS]
               && !dctx[qdfe_pkg::B_ERR_SENT];

  // ==========================================================
  // Sweep for interrupts held until arm
  wire [qdfe_pkg::SW_W-1:0] sctx = sw_r[scan_r];
  wire s_pend = sctx[qdfe_pkg::B_IRQ_REQ] || sctx[qdfe_pkg::B_NO_LAST];
  wire s_irq = !d_irq && sctx[qdfe_pkg::B_ARM] && s_pend && sctx[qdfe_pkg::B_IRQ_EN]
               && !sctx[qdfe_pkg::B_ERR_SENT];
  wire [QW-1:0] irq_q = d_irq ? done_qid_i : scan_r;
  wire [qdfe_pkg::SW_W-1:0] ictx = d_irq ? dctx : sctx;

  // ==========================================================
  // Fetch eligibility for the scanned queue
  wire [15:0] s_avail = ring_avail(sctx[15:0], cidx_r[scan_r],
                                   sctx[qdfe_pkg::B_RNG_LO +: 4]);
  wire [15:0] s_crd = 16'(credt_r[scan_r] - use_r[scan_r]);
  wire [1:0] s_sz = sctx[qdfe_pkg::B_SZ_LO +: 2];
  wire [15:0] s_mrrs = 16'(MRRS_BYTES >> (3 + s_sz));
  wire [15:0] s_lim1 = (s_avail < s_mrrs) ? s_avail : s_mrrs;
  wire [15:0] s_cnt = (sctx[qdfe_pkg::B_FCRD] && s_crd < s_lim1) ? s_crd : s_lim1;
  wire s_ok = sctx[qdfe_pkg::B_QEN] && sctx[qdfe_pkg::B_FAULT_LO +: 2] == 2'b00
              && s_avail != 16'h0000 && (!sctx[qdfe_pkg::B_FCRD] || s_crd != 16'h0000)
              && !pcie_r[scan_r]
              && fpnd_r[scan_r] <= qdfe_pkg::FPND_W'(sctx[qdfe_pkg::B_FMAX_LO +: 3])
              && 17'(s_cnt) <= 17'(free_r);
  wire fetch_go = s_ok && !fetch_valid_o && !s_irq;

  // ==========================================================
  // Completion storage path
  logic [BW-1:0] ram_rd;
  wire ram_we = cpl_valid_i;
  wire [BW-1:0] ram_wd = {sw_r[cpl_qid_i][qdfe_pkg::B_MM], sw_r[cpl_qid_i][qdfe_pkg::B_BYPASS],
                          cpl_last_i, cpl_err_i, cpl_qid_i, cpl_data_i};
  logic buf_ready;
  wire rd_go = (wp_r != rp_r) && buf_ready && !rdv_r;
  wire deliver = dsc_valid_o && dsc_ready_i;

  qdfe_ram #(.W(BW), .AW(qdfe_pkg::CPL_AW)) u_ram (
    .clk_i(clk_i),
    .we_i(ram_we),
    .waddr_i(wp_r),
    .wdata_i(ram_wd),
    .raddr_i(rp_r),
    .rdata_o(ram_rd)
  );

  qdfe_buf2 #(.W(BW)) u_buf (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(rdv_r),
    .in_ready_o(buf_ready),
    .in_data_i(ram_rd),
    .out_valid_o(dsc_valid_o),
    .out_ready_i(dsc_ready_i),
    .out_data_o({dsc_mm_o, dsc_bypass_o, dsc_last_o, dsc_err_o, dsc_qid_o, dsc_data_o})
  );

  // ==========================================================
  // Per-queue context update
  genvar q;
  generate
    for (q = 0; q < NQ; q = q + 1)
    begin : g_q
      wire sw_wr = ctx_wr_i && ctx_sel_i == qdfe_pkg::SEL_SW && ctx_qid_i == QW'(q);
      wire clr = ctx_clr_i && ctx_qid_i == QW'(q);
      wire p_hit = pidx_upd_i && pidx_qid_i == QW'(q);
      wire c_hit = cpl_valid_i && cpl_qid_i == QW'(q);
      wire dn_hit = done_valid_i && done_qid_i == QW'(q);
      wire i_hit = (d_irq || s_irq) && irq_q == QW'(q);
      wire f_hit = fetch_go && scan_r == QW'(q);
      wire l_hit = deliver && dsc_last_o && dsc_qid_o == QW'(q);
      wire pnd = done_r[q] != sw_r[q][15:0];

      always_ff @(posedge clk_i or posedge reset_i)
      begin
        if (reset_i)
        begin
          sw_r[q] <= qdfe_pkg::SW_RST;
          cidx_r[q] <= qdfe_pkg::IDX_RST;
          done_r[q] <= qdfe_pkg::IDX_RST;
          credt_r[q] <= qdfe_pkg::IDX_RST;
          use_r[q] <= qdfe_pkg::IDX_RST;
          fpnd_r[q] <= '0;
          pcie_r[q] <= 1'b0;
          act_r[q] <= 1'b0;
        end
        else
        begin
          if (sw_wr)
          begin
            sw_r[q] <= ctx_wdata_i;
          end
          else
          begin
            if (dn_hit && d_set_req)
            begin
              sw_r[q][qdfe_pkg::B_IRQ_REQ] <= 1'b1;
            end
            if (dn_hit && d_set_nolast)
            begin
              sw_r[q][qdfe_pkg::B_NO_LAST] <= 1'b1;
            end
            if (c_hit && cpl_err_i)
            begin
              sw_r[q][qdfe_pkg::B_FAULT_LO + qdfe_pkg::FAULT_DSC] <= 1'b1;
            end
            if (dn_hit && done_err_i)
            begin
              sw_r[q][qdfe_pkg::B_FAULT_LO + qdfe_pkg::FAULT_DMA] <= 1'b1;
            end
            if ((dn_hit && done_err_i && (d_wb || d_irq))
                || (i_hit && !d_irq && sctx[qdfe_pkg::B_IRQ_REQ]))
            begin
              sw_r[q][qdfe_pkg::B_ERR_SENT] <= 1'b1;
            end
            if (i_hit)
            begin
              sw_r[q][qdfe_pkg::B_ARM] <= 1'b0;
              sw_r[q][qdfe_pkg::B_IRQ_REQ] <= 1'b0;
              sw_r[q][qdfe_pkg::B_NO_LAST] <= 1'b0;
            end
            if (p_hit)
            begin
              sw_r[q][15:0] <= pidx_val_i;
              sw_r[q][qdfe_pkg::B_NO_LAST] <= 1'b0;
              if (pidx_arm_i)
              begin
                sw_r[q][qdfe_pkg::B_ARM] <= 1'b1;
              end
            end
          end
          if (clr)
          begin
            cidx_r[q] <= qdfe_pkg::IDX_RST;
            done_r[q] <= qdfe_pkg::IDX_RST;
            credt_r[q] <= qdfe_pkg::IDX_RST;
            use_r[q] <= qdfe_pkg::IDX_RST;
          end
          else
          begin
            if (c_hit)
            begin
              cidx_r[q] <= 16'(cidx_r[q] + 16'h0001);
            end
            if (dn_hit)
            begin
              done_r[q] <= done_cidx_i;
            end
            if (crd_valid_i && crd_qid_i == QW'(q))
            begin
              credt_r[q] <= 16'(credt_r[q] + crd_val_i);
            end
            if (f_hit && sctx[qdfe_pkg::B_FCRD])
            begin
              use_r[q] <= 16'(use_r[q] + s_cnt);
            end
          end
          fpnd_r[q] <= fpnd_r[q] + (f_hit ? 4'h1 : 4'h0) - (l_hit ? 4'h1 : 4'h0);
          if (f_hit)
          begin
            pcie_r[q] <= 1'b1;
          end
          else if (c_hit && cpl_last_i)
          begin
            pcie_r[q] <= 1'b0;
          end
          if (sw_r[q][qdfe_pkg::B_QEN])
          begin
            act_r[q] <= 1'b1;
          end
          else if (!pnd && fpnd_r[q] == 4'h0)
          begin
            act_r[q] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Shared datapath state and registered outputs
  wire [15:0] ev_old = sw_r[pidx_qid_i][15:0];
  wire ev_fire = pidx_upd_i && sw_r[pidx_qid_i][qdfe_pkg::B_QEN];
  wire [8:0] free_nxt = free_r - (fetch_go ? 9'(s_cnt) : 9'h000) + (deliver ? 9'h001 : 9'h000);
  wire [15:0] c_q = cidx_r[ctx_qid_i];
  wire [qdfe_pkg::HW_W-1:0] hw_view = {1'b0, fpnd_r[ctx_qid_i], 1'b0, act_r[ctx_qid_i],
                                       done_r[ctx_qid_i] != sw_r[ctx_qid_i][15:0],
                                       8'h00, use_r[ctx_qid_i], c_q};
  wire [qdfe_pkg::SW_W-1:0] rd_view = (ctx_sel_i == qdfe_pkg::SEL_SW) ? sw_r[ctx_qid_i] :
                                      (ctx_sel_i == qdfe_pkg::SEL_HW) ? qdfe_pkg::SW_W'(hw_view) :
                                      (ctx_sel_i == qdfe_pkg::SEL_CR) ?
                                      qdfe_pkg::SW_W'(credt_r[ctx_qid_i]) : '0;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      scan_r <= '0;
      free_r <= qdfe_pkg::CPL_FREE_RST;
      wp_r <= '0;
      rp_r <= '0;
      rdv_r <= 1'b0;
      ctx_rdata_o <= '0;
      fetch_valid_o <= 1'b0;
      fetch_qid_o <= '0;
      fetch_addr_o <= 64'h0000000000000000;
      fetch_cnt_o <= 16'h0000;
      wb_valid_o <= 1'b0;
      wb_qid_o <= '0;
      wb_cidx_o <= 16'h0000;
      irq_valid_o <= 1'b0;
      irq_qid_o <= '0;
      irq_vec_o <= '0;
      irq_aggr_o <= 1'b0;
      marker_valid_o <= 1'b0;
      marker_qid_o <= '0;
      queue_status_event_valid_o <= 1'b0;
      evt_qid_o <= '0;
      evt_avail_o <= 16'h0000;
      evt_arm_o <= 1'b0;
    end
    else
    begin
      scan_r <= QW'(scan_r + 1'b1);
      free_r <= free_nxt;
      wp_r <= ram_we ? wp_r + 1'b1 : wp_r;
      rp_r <= rd_go ? rp_r + 1'b1 : rp_r;
      rdv_r <= rd_go;
      ctx_rdata_o <= rd_view;
      if (fetch_go)
      begin
        fetch_valid_o <= 1'b1;
        fetch_qid_o <= scan_r;
        fetch_addr_o <= sctx[qdfe_pkg::B_BASE_LO +: 64] + (64'(cidx_r[scan_r]) << (3 + s_sz));
        fetch_cnt_o <= s_cnt;
      end
      else if (fetch_ready_i)
      begin
        fetch_valid_o <= 1'b0;
      end
      wb_valid_o <= d_wb;
      wb_qid_o <= done_qid_i;
      wb_cidx_o <= done_cidx_i;
      irq_valid_o <= d_irq || s_irq;
      irq_qid_o <= irq_q;
      irq_vec_o <= ictx[qdfe_pkg::B_VEC_LO +: qdfe_pkg::VEC_W];
      irq_aggr_o <= ictx[qdfe_pkg::B_AGGR];
      marker_valid_o <= d_mrk;
      marker_qid_o <= done_qid_i;
      queue_status_event_valid_o <= ev_fire;
      evt_qid_o <= pidx_qid_i;
      evt_avail_o <= ring_avail(pidx_val_i, ev_old, sw_r[pidx_qid_i][qdfe_pkg::B_RNG_LO +: 4]);
      evt_arm_o <= pidx_arm_i && !sw_r[pidx_qid_i][qdfe_pkg::B_ARM];
    end
  end

  // ==========================================================
  // Checks
  fetch_space_a: assert property (@(posedge clk_i) disable iff (reset_i)
    fetch_go |-> 17'(s_cnt) <= 17'(free_r)) else $error("fetch without space");
  fetch_single_a: assert property (@(posedge clk_i) disable iff (reset_i)
    fetch_go |-> !pcie_r[scan_r]) else $error("second fetch pending");
  fetch_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    fetch_valid_o && !fetch_ready_i |=> fetch_valid_o && $stable(fetch_addr_o))
    else $error("fetch dropped");
  irq_armed_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (d_irq || s_irq) |-> ictx[qdfe_pkg::B_ARM]) else $error("irq while disarmed");
  irq_vector_a: assert property (@(posedge clk_i) disable iff (reset_i)
    d_irq |=> irq_valid_o && irq_vec_o == $past(dctx[qdfe_pkg::B_VEC_LO +: qdfe_pkg::VEC_W]))
    else $error("wrong vector");
  err_silent_a: assert property (@(posedge clk_i) disable iff (reset_i)
    done_valid_i && dctx[qdfe_pkg::B_ERR_SENT] |=> !wb_valid_o && !marker_valid_o)
    else $error("status after error");
  wb_enable_a: assert property (@(posedge clk_i) disable iff (reset_i)
    wb_valid_o |-> $past(dctx[qdfe_pkg::B_WBK_EN])) else $error("writeback disabled");
  event_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i)
    ev_fire |=> queue_status_event_valid_o && evt_qid_o == $past(pidx_qid_i))
    else $error("event missing");
  marker_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
    done_valid_i && dctx[qdfe_pkg::B_MRK_DIS] |=> !marker_valid_o)
    else $error("marker not suppressed");
  free_bound_a: assert property (@(posedge clk_i) disable iff (reset_i)
    free_r <= qdfe_pkg::CPL_FREE_RST) else $error("space overflow");
endmodule

//--- inc/qdfe_pkg.sv
// Constants shared by the queue descriptor fetch engine files.
package qdfe_pkg;
  // ==========================================================
  // Software context layout
  localparam int SW_W = 140;
  localparam int B_AGGR = 139;
  localparam int B_VEC_LO = 128;
  localparam int VEC_W = 11;
  localparam int B_BASE_LO = 64;
  localparam int B_MM = 63;
  localparam int B_MRK_DIS = 62;
  localparam int B_IRQ_REQ = 61;
  localparam int B_ERR_SENT = 60;
  localparam int B_FAULT_LO = 58;
  localparam int B_NO_LAST = 57;
  localparam int B_IRQ_EN = 53;
  localparam int B_WBK_EN = 52;
  localparam int B_BYPASS = 50;
  localparam int B_SZ_LO = 48;
  localparam int B_RNG_LO = 44;
  localparam int B_FMAX_LO = 37;
  localparam int B_INTVL = 35;
  localparam int B_CHK = 34;
  localparam int B_FCRD = 33;
  localparam int B_QEN = 32;
  localparam int B_ARM = 16;
  localparam int FAULT_DMA = 1;
  localparam int FAULT_DSC = 0;
  // ==========================================================
  // Hardware and credit context layout
  localparam int HW_W = 48;
  localparam int CR_W = 32;
  localparam int IDX_W = 16;
  localparam int FPND_W = 4;
  // ==========================================================
  // Context select codes and reset values
  localparam logic [1:0] SEL_SW = 2'h0;
  localparam logic [1:0] SEL_HW = 2'h1;
  localparam logic [1:0] SEL_CR = 2'h2;
  localparam logic [SW_W-1:0] SW_RST = '0;
  localparam logic [IDX_W-1:0] IDX_RST = 16'h0000;
  // ==========================================================
  // Completion space per direction, in datapath-width entries
  localparam int CPL_ENTRIES = 256;
  localparam int CPL_AW = 8;
  localparam logic [8:0] CPL_FREE_RST = 9'h100;
  localparam int RING_MIN = 16;
endpackage

//--- rtl/qdfe_ram.sv
// Completion storage memory with registered read data.
`timescale 1ns/100ps
module qdfe_ram #(
  parameter int W = 72,
  parameter int AW = 8
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  logic [W-1:0] mem_r [0:(1<<AW)-1];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_r[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_r[raddr_i];
  end
endmodule

//--- rtl/qdfe_buf2.sv
// Two-entry buffer whose outputs come straight from flip-flops.
`timescale 1ns/100ps
module qdfe_buf2 #(
  parameter int W = 72
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  // ==========================================================
  // Head and spare stage
  logic spare_v_r;
  logic [W-1:0] spare_d_r;
  wire pop = out_valid_o && out_ready_i;
  wire push = in_valid_i && in_ready_o;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
      spare_v_r <= 1'b0;
      spare_d_r <= '0;
      in_ready_o <= 1'b1;
    end
    else
    begin
      if (!out_valid_o || pop)
      begin
        out_valid_o <= spare_v_r || push;
        out_data_o <= spare_v_r ? spare_d_r : in_data_i;
        spare_v_r <= spare_v_r && push;
        spare_d_r <= in_data_i;
        in_ready_o <= 1'b1;
      end
      else if (push)
      begin
        spare_v_r <= 1'b1;
        spare_d_r <= in_data_i;
        in_ready_o <= 1'b0;
      end
    end
  end
endmodule

//--- tb/qdfe_host_model.sv
// Host memory model that answers each descriptor read with one beat per descriptor.
`timescale 1ns/100ps
module qdfe_host_model (
  input wire logic clk_i,
  input wire logic fetch_valid_i,
  output logic fetch_ready_o,
  input wire logic [1:0] fetch_qid_i,
  input wire logic [63:0] fetch_addr_i,
  input wire logic [15:0] fetch_cnt_i,
  output logic cpl_valid_o,
  output logic [1:0] cpl_qid_o,
  output logic [63:0] cpl_data_o,
  output logic cpl_last_o
);
  // ==========
  // Read responder
  int seed = 9;
  logic [31:0] a;
  logic [15:0] n;
  initial
  begin
    {fetch_ready_o, cpl_valid_o, cpl_qid_o, cpl_data_o, cpl_last_o} = '0;
    forever
    begin
      @(negedge clk_i);
      if (fetch_valid_i === 1'b1)
      begin
        repeat ($unsigned($random(seed)) % 4) @(negedge clk_i);
        fetch_ready_o = 1'b1;
        a = fetch_addr_i[31:0];
        n = fetch_cnt_i;
        cpl_qid_o = fetch_qid_i;
        @(negedge clk_i);
        fetch_ready_o = 1'b0;
        // Gaps carry flipped data, so a stale word never passes for a fresh one.
        for (int k = 0; k < n; k++)
        begin
          cpl_valid_o = 1'b1;
          cpl_data_o = {a, 16'h0000, 16'(k)};
          cpl_last_o = k == n - 1;
          @(negedge clk_i);
          cpl_valid_o = 1'b0;
          cpl_data_o = ~cpl_data_o;
          cpl_last_o = 1'b0;
          @(negedge clk_i);
        end
      end
    end
  end
endmodule

//--- tb/queue_descriptor_fetch_engine_tb.sv
// Bench for the descriptor fetch engine, checked against queues of expected results.
`timescale 1ns/100ps
module queue_descriptor_fetch_engine_tb;
  logic clk_i = 1'b0, reset_i = 1'b1, ctx_wr_i = 1'b0, ctx_clr_i = 1'b0, pidx_upd_i = 1'b0;
  logic pidx_arm_i = 1'b0, crd_valid_i = 1'b0, cpl_err_i = 1'b0, dsc_ready_i = 1'b0;
  logic done_valid_i = 1'b0, done_err_i = 1'b0, fetch_ready_i, cpl_valid_i, cpl_last_i;
  logic [1:0] ctx_sel_i = 2'h0, ctx_qid_i = 2'h0, pidx_qid_i = 2'h0, crd_qid_i = 2'h0;
  logic [1:0] done_qid_i = 2'h0, cpl_qid_i, fetch_qid_o, dsc_qid_o, wb_qid_o, irq_qid_o;
  logic [1:0] marker_qid_o, evt_qid_o;
  logic [139:0] ctx_wdata_i = '0, ctx_rdata_o;
  logic [15:0] pidx_val_i = 16'h0000, crd_val_i = 16'h0000, done_cidx_i = 16'h0000;
  logic [15:0] fetch_cnt_o, wb_cidx_o, evt_avail_o, p, c, cnt, sz;
  logic [63:0] fetch_addr_o, cpl_data_i, dsc_data_o, base;
  logic [2:0] status_period_select_i = 3'h0;
  logic [10:0] irq_vec_o;
  logic fetch_valid_o, dsc_valid_o, dsc_err_o, dsc_last_o, dsc_mm_o, dsc_bypass_o, wb_valid_o;
  logic irq_valid_o, irq_aggr_o, marker_valid_o, queue_status_event_valid_o, evt_arm_o;
  int n_fail = 0, checks_done = 0, seed = 72, t;
  logic [69:0] dq[$];
  logic [1:0] mq[$];
  logic [17:0] wq[$];
  logic [13:0] iq[$];
  // ==========
  // Harness
  always #50 clk_i = ~clk_i;
  always @(negedge clk_i) dsc_ready_i <= ($random(seed) & 3) == 0;
  qdfe_engine i_qdfe_engine (.*);
  qdfe_host_model i_qdfe_host_model (.clk_i(clk_i), .fetch_valid_i(fetch_valid_o),
    .fetch_ready_o(fetch_ready_i), .fetch_qid_i(fetch_qid_o), .fetch_addr_i(fetch_addr_o),
    .fetch_cnt_i(fetch_cnt_o), .cpl_valid_o(cpl_valid_i), .cpl_qid_o(cpl_qid_i),
    .cpl_data_o(cpl_data_i), .cpl_last_o(cpl_last_i));
  task automatic chk(input logic [159:0] got, input logic [159:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic done_go(input logic [1:0] q, input logic [15:0] x, input logic e);
    @(negedge clk_i);
    done_valid_i = 1'b1;
    done_qid_i = q;
    done_cidx_i = x;
    done_err_i = e;
    @(negedge clk_i);
    done_valid_i = 1'b0;
    done_err_i = 1'b0;
  endtask
  always @(posedge clk_i)
  begin
    if (!reset_i && dsc_valid_o === 1'b1 && dsc_ready_i === 1'b1)
      chk({dsc_qid_o, dsc_mm_o, dsc_bypass_o, dsc_last_o, dsc_err_o, dsc_data_o},
        dq.size() ? dq.pop_front() : 'x, "descriptor");
    if (!reset_i && wb_valid_o === 1'b1)
      chk({wb_qid_o, wb_cidx_o}, wq.size() ? wq.pop_front() : 'x, "writeback");
    if (!reset_i && irq_valid_o === 1'b1)
      chk({irq_qid_o, irq_vec_o, irq_aggr_o},
        iq.size() ? iq.pop_front() : 'x, "interrupt");
    if (!reset_i && marker_valid_o === 1'b1)
      chk(marker_qid_o, mq.size() ? mq.pop_front() : 'x, "marker");
  end
  // ==========
  // Scenarios
  initial
  begin
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    for (int q = 0; q < 2; q++)
    begin
      // Queue 0 is bypass with 64-byte descriptors, queue 1 memory-mapped internal.
      sz = q ? 16'h0020 : 16'h0040;
      p = 16'(q ? 1 + $unsigned($random(seed)) % 14 : 9 + $unsigned($random(seed)) % 6);
      base = {32'h0000_0001, $random(seed) & 32'hFFFF_FFC0};
      ctx_qid_i = q[1:0];
      ctx_clr_i = 1'b1;
      @(negedge clk_i);
      ctx_clr_i = 1'b0;
      ctx_wr_i = 1'b1;
      ctx_wdata_i = {!q[0], 11'h7F0 + 11'(q), base, q[0], 9'h000, 3'h6, !q[0],
        q ? 2'h2 : 2'h3, 16'h0005, 32'h0000_0000};
      @(negedge clk_i);
      ctx_wr_i = 1'b0;
      @(negedge clk_i);
      chk(ctx_rdata_o, ctx_wdata_i, "context");
      pidx_qid_i = q[1:0];
      pidx_val_i = p;
      pidx_upd_i = 1'b1;
      pidx_arm_i = 1'b1;
      @(negedge clk_i);
      pidx_upd_i = 1'b0;
      pidx_arm_i = 1'b0;
      chk({queue_status_event_valid_o, evt_qid_o, evt_avail_o, evt_arm_o},
        {1'b1, q[1:0], p, 1'b1}, "event");
      for (c = 0; c < p; c += cnt)
      begin
        cnt = (p - c < 16'h0200 / sz) ? p - c : 16'h0200 / sz;
        t = 0;
        do
        begin
          @(posedge clk_i);
          t++;
        end
        while (!(fetch_valid_o === 1'b1 && fetch_ready_i === 1'b1) && t < 300);
        chk({fetch_qid_o, fetch_addr_o, fetch_cnt_o}, {q[1:0], base + c * sz, cnt}, "fetch");
        for (int k = 0; k < cnt; k++)
          dq.push_back({q[1:0], q[0], !q[0], k == cnt - 1, 1'b0, base[31:0] + 32'(c * sz),
            16'h0000, 16'(k)});
      end
      for (t = 0; t < 600 && dq.size() > 0; t++)
        @(posedge clk_i);
      chk(dq.size(), 0, "drain");
      wq.push_back({q[1:0], p});
      iq.push_back({q[1:0], 11'h7F0 + 11'(q), !q[0]});
      if (q)
        mq.push_back(2'h1);
      done_go(q[1:0], p, 1'b0);
      ctx_sel_i = qdfe_pkg::SEL_HW;
      @(negedge clk_i);
      chk({ctx_rdata_o[41:40], ctx_rdata_o[15:0]}, {2'b10, p}, "hardware view");
      ctx_sel_i = qdfe_pkg::SEL_SW;
    end
    wq.push_back({2'h1, p});
    mq.push_back(2'h1);
    done_go(2'h1, p, 1'b1);
    repeat (3) @(negedge clk_i);
    chk(ctx_rdata_o[61:59], 3'h7, "error flags");
    done_go(2'h1, p, 1'b0);
    repeat (20) @(posedge clk_i);
    chk(wq.size() + iq.size() + mq.size(), 0, "leftover");
    summarize();
  end
  initial
  begin
    #3000000;
    n_fail++;
    summarize();
  end
endmodule
